// >>> hdl/burst_master_pkg.sv
package burst_master_pkg;
    localparam int DATA_W  = 32;
    localparam int STRB_W  = DATA_W / 8;
    localparam int ADDR_W  = 32;
    localparam int ID_W    = 4;
    localparam int LEN_W   = 8;
    localparam int RESP_W  = 2;
    localparam int FIFO_D  = 16;
    localparam int OUTS_W  = 5;
    localparam logic [OUTS_W-1:0] OUTS_MAX  = 5'h10;
    localparam logic [OUTS_W-1:0] OUTS_ZERO = 5'h00;
    localparam logic [OUTS_W-1:0] OUTS_ONE  = 5'h01;
    localparam logic [LEN_W-1:0]  LEN_ZERO  = 8'h00;
    localparam logic [LEN_W-1:0]  LEN_ONE   = 8'h01;

    typedef struct packed {
        logic [ID_W-1:0]   id;
        logic [ADDR_W-1:0] addr;
        logic [LEN_W-1:0]  len;
        logic [2:0]        size;
        logic [1:0]        burst;
    } addr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } wbeat_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
        logic              last;
    } wdat_t;

    typedef struct packed {
        logic [ID_W-1:0]   id;
        logic [DATA_W-1:0] data;
        logic [RESP_W-1:0] resp;
        logic              last;
    } rdat_t;

    typedef struct packed {
        logic [ID_W-1:0]   id;
        logic [RESP_W-1:0] resp;
    } bresp_t;
endpackage : burst_master_pkg

// >>> hdl/burst_master.sv

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;
    logic [AW:0]      count_nxt;

    // the full mark needs AW+1 bits: DEPTH cut to AW bits would read as empty
    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        count_nxt = count_r;
        case ({push, pop})
            2'h2:    count_nxt = count_r + (AW+1)'(1);
            2'h1:    count_nxt = count_r - (AW+1)'(1);
            default: count_nxt = count_r;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
            end
            count_r <= count_nxt;
        end
    end
endmodule : sync_fifo

module reg_slice #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    // one stage, one cycle of latency; refills in the cycle it drains
    logic             full_r;
    logic [WIDTH-1:0] data_r;

    assign inReady  = !full_r || outReady;
    assign outValid = full_r;
    assign outData  = data_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            full_r <= 1'b0;
        end else if (inReady) begin
            full_r <= inValid;
        end
    end

    always_ff @(posedge core_clk) begin
        if (inValid && inReady) begin
            data_r <= inData;
        end
    end
endmodule : reg_slice

module burst_master (
    input  wire logic                           core_clk,
    input  wire logic                           sys_rst,
    // user: write command
    input  wire logic                           wrCmdValid,
    output logic                                wrCmdReady,
    input  wire burst_master_pkg::addr_t        wrCmd,
    // user: write beats, counted against the command's length
    input  wire logic                           wrBeatValid,
    output logic                                wrBeatReady,
    input  wire burst_master_pkg::wbeat_t       wrBeat,
    // user: write completions
    output logic                                wrDoneValid,
    input  wire logic                           wrDoneReady,
    output burst_master_pkg::bresp_t            wrDone,
    // user: read command
    input  wire logic                           rdCmdValid,
    output logic                                rdCmdReady,
    input  wire burst_master_pkg::addr_t        rdCmd,
    // user: read beats
    output logic                                rdBeatValid,
    input  wire logic                           rdBeatReady,
    output burst_master_pkg::rdat_t             rdBeat,
    output logic [burst_master_pkg::OUTS_W-1:0] wrOutstanding,
    output logic [burst_master_pkg::OUTS_W-1:0] rdOutstanding,
    // bus side
    output logic                                busResetN,
    output logic                                awValid,
    input  wire logic                           awReady,
    output burst_master_pkg::addr_t             awInfo,
    output logic                                wValid,
    input  wire logic                           wReady,
    output burst_master_pkg::wdat_t             wInfo,
    input  wire logic                           bValid,
    output logic                                bReady,
    input  wire burst_master_pkg::bresp_t       bInfo,
    output logic                                arValid,
    input  wire logic                           arReady,
    output burst_master_pkg::addr_t             arInfo,
    input  wire logic                           rValid,
    output logic                                rReady,
    input  wire burst_master_pkg::rdat_t        rInfo
);
    // length queue: one entry per accepted write command, sets beat count per burst
    logic [burst_master_pkg::LEN_W-1:0] lenQ_r [burst_master_pkg::FIFO_D];
    logic [3:0]                         lenWr_r;
    logic [3:0]                         lenRd_r;
    logic [burst_master_pkg::OUTS_W-1:0] lenCnt_r;
    logic [burst_master_pkg::LEN_W-1:0] beatCnt_r;
    logic                               fifoInValid;
    logic                               fifoInReady;
    burst_master_pkg::wdat_t            fifoIn;
    logic                               awFire;
    logic                               wPush;
    logic                               lenPop;
    logic                               lastBeat;
    logic                               arFire;
    logic                               bFire;
    logic                               rEndFire;
    logic [burst_master_pkg::OUTS_W-1:0] wrOpen_nxt;
    logic [burst_master_pkg::OUTS_W-1:0] rdOpen_nxt;
    logic [burst_master_pkg::OUTS_W-1:0] lenCnt_nxt;
    logic [burst_master_pkg::LEN_W-1:0] beatCnt_nxt;

    assign busResetN = ~sys_rst;

    // address channels: stalls are direct, payload stable since user holds it
    assign awValid    = wrCmdValid && (wrOutstanding != burst_master_pkg::OUTS_MAX)
                        && (lenCnt_r != burst_master_pkg::OUTS_MAX);
    assign awInfo     = wrCmd;
    assign wrCmdReady = awReady && awValid;
    assign awFire     = awValid && awReady;
    assign arValid    = rdCmdValid && (rdOutstanding != burst_master_pkg::OUTS_MAX);
    assign arInfo     = rdCmd;
    assign rdCmdReady = arReady && arValid;
    assign arFire     = arValid && arReady;

    // beats only go forward once a command gives their length; address may lead data
    assign lenPop      = wPush && lastBeat;
    assign lastBeat    = (beatCnt_r == lenQ_r[lenRd_r]);
    assign fifoInValid = wrBeatValid && (lenCnt_r != burst_master_pkg::OUTS_ZERO);
    assign wrBeatReady = fifoInReady && (lenCnt_r != burst_master_pkg::OUTS_ZERO);
    assign wPush       = fifoInValid && fifoInReady;
    assign fifoIn      = '{data: wrBeat.data, strb: wrBeat.strb, last: lastBeat};

    // buffered write data, decoupled from responses
    sync_fifo #(
        .WIDTH ($bits(burst_master_pkg::wdat_t)),
        .DEPTH (burst_master_pkg::FIFO_D)
    ) wrDataFifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (wValid),
        .outReady (wReady),
        .outData  (wInfo)
    );

    always_ff @(posedge core_clk) begin
        if (awFire) begin
            lenQ_r[lenWr_r] <= wrCmd.len;
        end
    end

    always_comb begin
        lenCnt_nxt = lenCnt_r;
        case ({awFire, lenPop})
            2'h2:    lenCnt_nxt = lenCnt_r + burst_master_pkg::OUTS_ONE;
            2'h1:    lenCnt_nxt = lenCnt_r - burst_master_pkg::OUTS_ONE;
            default: lenCnt_nxt = lenCnt_r;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lenWr_r  <= '0;
            lenRd_r  <= '0;
            lenCnt_r <= burst_master_pkg::OUTS_ZERO;
        end else begin
            if (awFire) begin
                lenWr_r <= lenWr_r + 4'h1;
            end
            if (lenPop) begin
                lenRd_r <= lenRd_r + 4'h1;
            end
            lenCnt_r <= lenCnt_nxt;
        end
    end

    always_comb begin
        beatCnt_nxt = beatCnt_r;
        if (wPush) begin
            beatCnt_nxt = lastBeat ? burst_master_pkg::LEN_ZERO
                                   : beatCnt_r + burst_master_pkg::LEN_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            beatCnt_r <= burst_master_pkg::LEN_ZERO;
        end else begin
            beatCnt_r <= beatCnt_nxt;
        end
    end

    // responses reach the user through one slice each, any order of ids
    // slices add one cycle of latency; when full, the user's ready drives the bus ready directly
    reg_slice #(
        .WIDTH ($bits(burst_master_pkg::bresp_t))
    ) wrDoneSlice (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inValid  (bValid),
        .inReady  (bReady),
        .inData   (bInfo),
        .outValid (wrDoneValid),
        .outReady (wrDoneReady),
        .outData  (wrDone)
    );

    reg_slice #(
        .WIDTH ($bits(burst_master_pkg::rdat_t))
    ) rdBeatSlice (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inValid  (rValid),
        .inReady  (rReady),
        .inData   (rInfo),
        .outValid (rdBeatValid),
        .outReady (rdBeatReady),
        .outData  (rdBeat)
    );

    assign bFire       = bValid && bReady;
    assign rEndFire    = rValid && rReady && rInfo.last;

    always_comb begin
        wrOpen_nxt = wrOutstanding;
        case ({awFire, bFire})
            2'h2:    wrOpen_nxt = wrOutstanding + burst_master_pkg::OUTS_ONE;
            2'h1:    wrOpen_nxt = wrOutstanding - burst_master_pkg::OUTS_ONE;
            default: wrOpen_nxt = wrOutstanding;
        endcase
    end

    always_comb begin
        rdOpen_nxt = rdOutstanding;
        case ({arFire, rEndFire})
            2'h2:    rdOpen_nxt = rdOutstanding + burst_master_pkg::OUTS_ONE;
            2'h1:    rdOpen_nxt = rdOutstanding - burst_master_pkg::OUTS_ONE;
            default: rdOpen_nxt = rdOutstanding;
        endcase
    end

    // outstanding counters; one write retires per response, one read per last beat
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrOutstanding <= burst_master_pkg::OUTS_ZERO;
        end else begin
            wrOutstanding <= wrOpen_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdOutstanding <= burst_master_pkg::OUTS_ZERO;
        end else begin
            rdOutstanding <= rdOpen_nxt;
        end
    end
endmodule : burst_master

// >>> tb/burst_master_props.sv
module burst_master_props (
    input  wire logic                                core_clk, sys_rst, busResetN,
    input  wire logic                                awValid, awReady, wValid, wReady,
    input  wire logic                                bValid, bReady, arValid, arReady,
    input  wire logic                                rValid, rReady,
    input  wire burst_master_pkg::addr_t             awInfo,
    input  wire burst_master_pkg::wdat_t             wInfo,
    input  wire burst_master_pkg::rdat_t             rInfo,
    input  wire logic [burst_master_pkg::OUTS_W-1:0] wrOutstanding, rdOutstanding
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence wrInc; awValid && awReady && !(bValid && bReady); endsequence
    sequence wrDec; bValid && bReady && !(awValid && awReady); endsequence
    sequence rdDec; rValid && rReady && rInfo.last && !(arValid && arReady); endsequence
    sequence rdMid; rValid && rReady && !rInfo.last && !(arValid && arReady); endsequence

    aw_hold_a: assert property (awValid && !awReady |=> awValid && $stable(awInfo))
        else $error("write address dropped or changed before accept");
    w_hold_a: assert property (wValid && !wReady |=> wValid && $stable(wInfo))
        else $error("write beat dropped or changed before accept");
    wr_inc_a: assert property (wrInc |=> wrOutstanding == $past(wrOutstanding) + 5'h01)
        else $error("open write count did not rise");
    wr_dec_a: assert property (wrDec |=> wrOutstanding == $past(wrOutstanding) - 5'h01)
        else $error("open write count did not fall");
    rd_dec_a: assert property (rdDec |=> rdOutstanding == $past(rdOutstanding) - 5'h01)
        else $error("open read count did not fall on last beat");
    rd_mid_a: assert property (rdMid |=> $stable(rdOutstanding))
        else $error("open read count moved on a middle beat");
    limit_a: assert property (wrOutstanding == burst_master_pkg::OUTS_MAX |-> !awValid)
        else $error("write address offered with all slots open");
    rst_out_a: assert property (disable iff (1'b0) busResetN != sys_rst)
        else $error("bus reset not the inverse of reset");
    quiet_a: assert property ($past(sys_rst) |-> !wValid)
        else $error("write beat offered right after reset");
endmodule : burst_master_props

bind burst_master burst_master_props chk (.core_clk, .sys_rst, .busResetN, .awValid,
    .awReady, .wValid, .wReady, .bValid, .bReady, .arValid, .arReady, .rValid, .rReady,
    .awInfo, .wInfo, .rInfo, .wrOutstanding, .rdOutstanding);

// >>> tb/burst_slave.sv
module burst_slave (
    input  wire logic                    core_clk, busResetN,
    input  wire logic [1:0]              slow,
    input  wire logic                    awValid, wValid, bReady, arValid, rReady,
    output logic                         awReady, wReady, bValid, arReady, rValid,
    input  wire burst_master_pkg::addr_t awInfo, arInfo,
    input  wire burst_master_pkg::wdat_t wInfo,
    output burst_master_pkg::bresp_t     bInfo,
    output burst_master_pkg::rdat_t      rInfo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]              ids[$], pend[$];
    burst_master_pkg::addr_t rq[$];
    logic [7:0]              beat;
    logic                    tgl;
    // addresses always taken: write ids are queued here until their last beat
    assign awReady = 1'b1;
    assign arReady = 1'b1;
    assign wReady  = (slow == 2'h0) || (slow == 2'h1 && tgl);
    always @(posedge core_clk or negedge busResetN) begin
        if (!busResetN) begin
            ids.delete();
            pend.delete();
            rq.delete();
            beat   = 8'h00;
            tgl    <= 1'b0;
            bValid <= 1'b0;
            rValid <= 1'b0;
            bInfo  <= '1;
            rInfo  <= '1;
        end else begin
            tgl <= !tgl;
            if (bValid && bReady) void'(pend.pop_front());
            if (awValid && awReady) ids.push_back(awInfo.id);
            if (wValid && wReady && wInfo.last) pend.push_back(ids.pop_front());
            bValid <= pend.size() > 0;
            bInfo  <= (pend.size() > 0) ? {pend[0], 2'h0} : '1;
            if (rValid && rReady) begin
                if (rInfo.last) begin
                    void'(rq.pop_front());
                    beat = 8'h00;
                end else begin
                    beat = beat + 8'h01;
                end
            end
            if (arValid && arReady) rq.push_back(arInfo);
            // a stall never withdraws a beat already offered
            rValid <= rq.size() > 0 && (rValid || slow != 2'h2);
            rInfo  <= (rq.size() > 0) ?
                {rq[0].id, rq[0].addr + 32'(beat), 2'h0, beat == rq[0].len} : '1;
        end
    end
endmodule : burst_slave

// >>> tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, wrCmdValid, wrCmdReady, wrBeatValid, wrBeatReady, wrDoneValid;
    logic wrDoneReady, rdCmdValid, rdCmdReady, rdBeatValid, rdBeatReady, busResetN;
    logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    logic [1:0]               slow;
    logic [4:0]               wrOutstanding, rdOutstanding;
    burst_master_pkg::addr_t  wrCmd, rdCmd, awInfo, arInfo;
    burst_master_pkg::wbeat_t wrBeat;
    burst_master_pkg::wdat_t  wInfo;
    burst_master_pkg::bresp_t wrDone, bInfo;
    burst_master_pkg::rdat_t  rdBeat, rInfo;
    int                       errors, n_checks, wSeen, bSeen, rSeen, i;
    logic [63:0]              wExp[$], bExp[$], rExp[$];

    burst_master dut (.core_clk, .sys_rst, .wrCmdValid, .wrCmdReady, .wrCmd, .wrBeatValid,
        .wrBeatReady, .wrBeat, .wrDoneValid, .wrDoneReady, .wrDone, .rdCmdValid, .rdCmdReady,
        .rdCmd, .rdBeatValid, .rdBeatReady, .rdBeat, .wrOutstanding, .rdOutstanding, .busResetN,
        .awValid, .awReady, .awInfo, .wValid, .wReady, .wInfo, .bValid, .bReady, .bInfo,
        .arValid, .arReady, .arInfo, .rValid, .rReady, .rInfo);
    burst_slave slv (.core_clk, .busResetN, .slow, .awValid, .wValid, .bReady, .arValid,
        .rReady, .awReady, .wReady, .bValid, .arReady, .rValid, .awInfo, .arInfo, .wInfo,
        .bInfo, .rInfo);

    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic guard(int n);
        if (n >= 400) begin
            errors++;
            $display("BAD wait exp done seen hang");
            conclude();
        end
        #1;
    endtask : guard

    // k: 0 write command, 1 read command, 2 write beat (len bit 0 is last), 3 idle
    task automatic xfer(int k, logic [3:0] id, logic [7:0] len, logic [31:0] a);
        int n;
        wrCmd       = '{id, a, len, 3'h2, 2'h1};
        rdCmd       = wrCmd;
        wrBeat      = '{a, a[3:0]};
        wrCmdValid  = (k == 0);
        rdCmdValid  = (k == 1);
        wrBeatValid = (k == 2);
        if (k == 2) wExp.push_back({a, a[3:0], len[0]});
        if (k < 3) begin
            // ready is settled at the falling edge and holds to the rising one
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (n < 400 && !(k == 0 ? wrCmdReady : k == 1 ? rdCmdReady : wrBeatReady));
            @(posedge core_clk);
            guard(n);
        end
    endtask : xfer

    // handshakes seen settled, half a cycle before the edge that takes them
    always @(negedge core_clk) begin
        if (wValid && wReady) begin
            chk("wInfo", 64'(wInfo), wExp.pop_front());
            wSeen++;
        end
        if (wrDoneValid && wrDoneReady) begin
            chk("wrDone", 64'(wrDone), bExp.pop_front());
            bSeen++;
        end
        if (rdBeatValid && rdBeatReady) begin
            chk("rdBeat", 64'(rdBeat), rExp.pop_front());
            rSeen++;
        end
    end

    task automatic t_write;
        slow = 2'h1;
        bExp.push_back(64'h3 << 2);
        bExp.push_back(64'h5 << 2);
        xfer(0, 4'h3, 8'h03, 32'h0000_0100);
        xfer(0, 4'h5, 8'h00, 32'h0000_0200);
        for (int j = 0; j < 5; j++) xfer(2, 4'h0, 8'(j == 3 || j == 4), 32'h0000_1000 + j);
        xfer(3, 4'h0, 8'h00, 32'h0000_0000);
        for (i = 0; i < 400 && bSeen < 2; i++) @(posedge core_clk);
        guard(i);
        chk("wrOutstanding", 64'(wrOutstanding), 64'h0);
        $display("write test done");
    endtask : t_write

    task automatic t_read;
        for (int j = 0; j < 2; j++) rExp.push_back({4'h6, 32'h0000_0300 + j, 2'h0, j == 1});
        rExp.push_back({4'h7, 32'h0000_0400, 2'h0, 1'b1});
        xfer(1, 4'h6, 8'h01, 32'h0000_0300);
        xfer(1, 4'h7, 8'h00, 32'h0000_0400);
        xfer(3, 4'h0, 8'h00, 32'h0000_0000);
        for (i = 0; i < 400 && rSeen < 3; i++) @(posedge core_clk);
        guard(i);
        chk("rdOutstanding", 64'(rdOutstanding), 64'h0);
        $display("read test done");
    endtask : t_read

    task automatic t_limit;
        wrDoneReady = 1'b0;
        for (int j = 0; j < 16; j++) begin
            bExp.push_back(64'(j) << 2);
            xfer(0, 4'(j), 8'h00, 32'h0000_0500 + j);
        end
        repeat (3) @(posedge core_clk);
        chk("wrCmdReady", 64'(wrCmdReady), 64'h0);
        chk("wrOutstanding", 64'(wrOutstanding), 64'h10);
        guard(0);
        xfer(3, 4'h0, 8'h00, 32'h0000_0000);
        slow = 2'h2;
        for (int j = 0; j < 16; j++) xfer(2, 4'h0, 8'h01, 32'h0000_2000 + j);
        xfer(3, 4'h0, 8'h00, 32'h0000_0000);
        repeat (4) @(posedge core_clk);
        chk("wValid", 64'(wValid), 64'h1);
        chk("wSeen", 64'(wSeen), 64'h5);
        guard(0);
        slow = 2'h0;
        for (i = 0; i < 400 && wSeen < 21; i++) @(posedge core_clk);
        guard(i);
        wrDoneReady = 1'b1;
        for (i = 0; i < 400 && bSeen < 18; i++) @(posedge core_clk);
        guard(i);
        chk("wrOutstanding", 64'(wrOutstanding), 64'h0);
        $display("limit test done");
    endtask : t_limit

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        {errors, n_checks, wSeen, bSeen, rSeen} = '0;
        {sys_rst, wrDoneReady, rdBeatReady, slow} = 5'h1C;
        xfer(3, 4'h0, 8'h00, 32'h0000_0000);
        repeat (20) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        chk("dataWidth", 64'(burst_master_pkg::STRB_W * 8), 64'(burst_master_pkg::DATA_W));
        t_write();
        t_read();
        t_limit();
        conclude();
    end
endmodule : tb_top
